// ### logic/gis_pkg.sv
// Constants, register map and decode types for the GPIO interrupt
// status block.
// Assumes an APB slave at byte addresses, 32-bit data, 8 pins.
//
// Behaviour
// - Unmasked pending pins alone reach the interrupt controller
// - Trigger condition sets raw bit regardless of mask
// - Level pins clear raw bit when level leaves
// - Edge pins hold raw bit until cleared
// - Masked status reads raw AND mask, read-only
// - Written one clears an edge pin's status
// - Written one leaves a level pin untouched
// - Written zeros in clear register do nothing
// - Raw status read-only, upper bits zero, reset zero
// - One combined interrupt output for the port
// - Sense bit selects edge (0) or level (1)
// - Polarity bit selects rising/high (1) or falling/low (0)
// - Both-edges bit overrides polarity in edge mode
`default_nettype none

package gis_pkg;

    // ****************************************************
    // Sizes
    // ****************************************************
    localparam int NPINS = 8; // Pins in the port
    localparam int AW = 12; // Decoded address bits
    localparam int DW = 32; // APB data width

    // ****************************************************
    // Register byte offsets
    // ****************************************************
    localparam logic [11:0] OFF_DETECT_TYPE = 12'h404; // Sense select
    localparam logic [11:0] OFF_DUAL_EDGE = 12'h408; // Both edges
    localparam logic [11:0] OFF_POLARITY = 12'h40C; // Event polarity
    localparam logic [11:0] OFF_INT_MASK = 12'h410; // Mask enables
    localparam logic [11:0] OFF_RAW_STAT = 12'h414; // Raw status
    localparam logic [11:0] OFF_MASK_STAT = 12'h418; // Masked status
    localparam logic [11:0] OFF_CLEAR = 12'h41C; // Write-one clear

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam logic [7:0] RST_CFG = 8'h00; // All config bits
    localparam logic [7:0] RST_STAT = 8'h00; // Status bits
    localparam logic [31:0] RST_RDATA = 32'h0000_0000; // Read data

    // ****************************************************
    // Field values
    // ****************************************************
    localparam logic SENSE_EDGE = 1'b0; // Edge detection
    localparam logic SENSE_LEVEL = 1'b1; // Level detection

    // Register selected by an address
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_DETECT = 3'b001,
        SEL_DUAL = 3'b010,
        SEL_POL = 3'b011,
        SEL_MASK = 3'b100,
        SEL_RAW = 3'b101,
        SEL_MIS = 3'b110,
        SEL_CLR = 3'b111
    } gis_sel_e;

endpackage : gis_pkg

`default_nettype wire

// ### logic/gis_top.sv
// GPIO port interrupt status block: pin synchronisers, edge and
// level detection, raw and masked status, write-one clear, mask
// and one combined interrupt line, all behind an APB slave.
// Assumes pins may be asynchronous; one clock, pclk.
`default_nettype none

module gis_top
    import gis_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_in,
    output logic int_out
);

    // ****************************************************
    // Decode
    // ****************************************************

    // Address to register select, shared by read and write
    function automatic gis_sel_e decode(input logic [11:0] a);
        gis_sel_e s;
        s = SEL_NONE;
        unique case (a)
            OFF_DETECT_TYPE: s = SEL_DETECT;
            OFF_DUAL_EDGE: s = SEL_DUAL;
            OFF_POLARITY: s = SEL_POL;
            OFF_INT_MASK: s = SEL_MASK;
            OFF_RAW_STAT: s = SEL_RAW;
            OFF_MASK_STAT: s = SEL_MIS;
            OFF_CLEAR: s = SEL_CLR;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction

    // ****************************************************
    // Storage
    // ****************************************************
    logic [7:0] sync1_q; // First sync stage, read by sync2 only
    logic [7:0] sync2_q; // Stable pin sample
    logic [7:0] hist_q; // Previous stable sample
    logic [7:0] detect_type_select_q; // 1 = level sense
    logic [7:0] dual_edge_enable_q; // 1 = both edges
    logic [7:0] trigger_polarity_q; // 1 = rising or high
    logic [7:0] pin_int_enable_bits_q; // Mask enables
    logic [7:0] raw_pending_bits_q; // Raw status
    logic [7:0] raw_pending_bits_d; // Next raw status
    logic [7:0] masked_pending_bits; // Raw AND mask
    logic [7:0] pending_clear_bits; // Clear strobes this cycle
    logic [7:0] edge_hit; // Edge trigger seen this cycle
    logic [7:0] level_hit; // Level trigger active now
    logic [31:0] rdata_q; // Read data, captured in setup
    logic err_q; // Unmapped address seen in setup
    logic setup_ph; // APB setup cycle
    logic access_ph; // APB access cycle
    logic wr_acc; // Write completing this edge
    gis_sel_e sel; // Register addressed

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_acc = access_ph & pwrite;
    assign sel = decode(paddr);

    // ****************************************************
    // Pin synchroniser
    // ****************************************************

    // Two flops against metastability, a third for edges
    // Reset to zero, so a pin held high at release looks like a rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= RST_STAT;
            sync2_q <= RST_STAT;
            hist_q <= RST_STAT;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            hist_q <= sync2_q;
        end
    end

    // ****************************************************
    // Configuration registers
    // ****************************************************

    // Software-owned settings; writes land at access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detect_type_select_q <= RST_CFG;
            dual_edge_enable_q <= RST_CFG;
            trigger_polarity_q <= RST_CFG;
            pin_int_enable_bits_q <= RST_CFG;
        end else if (wr_acc) begin
            // Read-only and unmapped targets store nothing
            if (sel == SEL_DETECT) begin
                detect_type_select_q <= pwdata[7:0];
            end
            if (sel == SEL_DUAL) begin
                dual_edge_enable_q <= pwdata[7:0];
            end
            if (sel == SEL_POL) begin
                trigger_polarity_q <= pwdata[7:0];
            end
            if (sel == SEL_MASK) begin
                pin_int_enable_bits_q <= pwdata[7:0];
            end
        end
    end

    // ****************************************************
    // Detection
    // ****************************************************

    // Only ones written to the clear register act
    assign pending_clear_bits = (wr_acc && sel == SEL_CLR) ?
        pwdata[7:0] : RST_STAT;

    // Per-pin trigger and next status
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        logic rise; // Low to high between samples
        logic fall; // High to low between samples
        assign rise = sync2_q[i] & ~hist_q[i];
        assign fall = ~sync2_q[i] & hist_q[i];

        // Both-edges wins over polarity
        assign edge_hit[i] = dual_edge_enable_q[i] ? (rise | fall) :
            (trigger_polarity_q[i] ? rise : fall);

        // Level match against polarity
        assign level_hit[i] = trigger_polarity_q[i] ? sync2_q[i] :
            ~sync2_q[i];

        // Level pins follow the pin, so the clear has no hold on them;
        // edge pins are sticky, and a new edge beats a clear
        always_comb begin
            if (detect_type_select_q[i] == SENSE_LEVEL) begin
                raw_pending_bits_d[i] = level_hit[i];
            end else begin
                raw_pending_bits_d[i] = edge_hit[i] |
                    (raw_pending_bits_q[i] &
                    ~pending_clear_bits[i]);
            end
        end
    end

    // ****************************************************
    // Status
    // ****************************************************

    // Raw status, independent of mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_pending_bits_q <= RST_STAT;
        end else begin
            raw_pending_bits_q <= raw_pending_bits_d;
        end
    end

    // Masked view and the one port interrupt
    assign masked_pending_bits = raw_pending_bits_q &
        pin_int_enable_bits_q;
    assign int_out = |masked_pending_bits;

    // ****************************************************
    // APB read path
    // ****************************************************

    // Data captured in setup so prdata comes from a flop;
    // status can move one cycle before the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= RST_RDATA;
            err_q <= 1'b0;
        end else if (setup_ph) begin
            err_q <= (sel == SEL_NONE);
            rdata_q <= RST_RDATA;
            unique case (sel)
                SEL_DETECT: rdata_q[7:0] <= detect_type_select_q;
                SEL_DUAL: rdata_q[7:0] <= dual_edge_enable_q;
                SEL_POL: rdata_q[7:0] <= trigger_polarity_q;
                SEL_MASK: rdata_q[7:0] <= pin_int_enable_bits_q;
                SEL_RAW: rdata_q[7:0] <= raw_pending_bits_q;
                SEL_MIS: rdata_q[7:0] <= masked_pending_bits;
                // Clear register and holes read zero
                SEL_CLR: rdata_q[7:0] <= RST_STAT;
                SEL_NONE: rdata_q[7:0] <= RST_STAT;
            endcase
        end
    end

    // No wait states
    assign pready = access_ph;
    assign pslverr = access_ph & err_q;
    assign prdata = rdata_q;

    // ****************************************************
    // Checks
    // ****************************************************
    // All checks run on pclk and rest while reset is low
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    for (genvar i = 0; i < NPINS; i++) begin : g_chk
        logic clr_i; // Clear strobe for this pin
        logic edge_mode; // Pin is edge sensed
        assign clr_i = wr_acc && sel == SEL_CLR && pwdata[i];
        assign edge_mode = ~detect_type_select_q[i];

        // Rising edge with rising polarity sets status
        edge_set_a: assert property (
            edge_mode && !dual_edge_enable_q[i] && trigger_polarity_q[i]
            && sync2_q[i] && !hist_q[i]
            |=> raw_pending_bits_q[i])
            else $error("rising edge did not set status");

        // Falling edge with both-edges on sets status
        dual_edge_a: assert property (
            edge_mode && dual_edge_enable_q[i] && !sync2_q[i]
            && hist_q[i] |=> raw_pending_bits_q[i])
            else $error("dual edge missed a falling edge");

        // Sticky edge status survives without a clear
        edge_hold_a: assert property (
            edge_mode && raw_pending_bits_q[i] && !clr_i
            |=> raw_pending_bits_q[i])
            else $error("edge status dropped without clear");

        // Clear with no new edge drops status and masked bit
        edge_clear_a: assert property (
            edge_mode && clr_i && !edge_hit[i]
            |=> !raw_pending_bits_q[i] && !masked_pending_bits[i])
            else $error("clear did not drop edge status");

        // Level pin keeps status while level holds, clear or not
        level_keep_a: assert property (
            detect_type_select_q[i] && $stable(detect_type_select_q[i])
            && level_hit[i] |=> raw_pending_bits_q[i])
            else $error("level status lost while active");

        // Level pin status falls once level departs
        level_drop_a: assert property (
            detect_type_select_q[i] && !level_hit[i]
            |=> !raw_pending_bits_q[i])
            else $error("level status stuck after level left");

        // Clear write leaves an active level pin set
        level_clr_a: assert property (
            !edge_mode && clr_i && level_hit[i]
            |=> raw_pending_bits_q[i])
            else $error("clear write dropped level status");

        // Masked pin never drives the interrupt alone
        mask_gate_a: assert property (
            raw_pending_bits_q[i] && !pin_int_enable_bits_q[i]
            && ((masked_pending_bits & ~(8'h01 << i)) == 8'h00)
            |-> !int_out)
            else $error("masked pin raised interrupt");
    end

    // Masked status read returns raw AND mask of setup cycle
    mis_read_a: assert property (
        setup_ph && sel == SEL_MIS |=> pready &&
        prdata == {24'h000000, $past(raw_pending_bits_q &
        pin_int_enable_bits_q)})
        else $error("masked status read wrong");

    // Reserved raw status bits read zero
    reserved_zero_a: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("reserved bits not zero");

    // Zero-valued clear drops no edge status; new edges may still set
    zero_write_a: assert property (
        wr_acc && sel == SEL_CLR && pwdata[7:0] == 8'h00
        |=> ($past(raw_pending_bits_q & ~detect_type_select_q) &
        ~raw_pending_bits_q) == 8'h00)
        else $error("zero clear write dropped edge status");

    // Main scenarios
    edge_then_clear_c: cover property (
        raw_pending_bits_q[0] && !detect_type_select_q[0]
        ##[1:20] !raw_pending_bits_q[0]);
    level_irq_c: cover property (
        detect_type_select_q[3] && int_out);
    // Both-edges pin caught on its falling edge
    dual_fall_c: cover property (
        dual_edge_enable_q[2] && raw_pending_bits_q[2] && !sync2_q[2]);
    unmapped_c: cover property (pready && pslverr);
    mis_read_c: cover property (
        pready && !pwrite && prdata[7:0] != 8'h00);

endmodule // gis_top

`default_nettype wire

// ### bench/gis_pin_src.sv
// Pin source model: the outside logic that drives the port's pins.
// Assumes the bench sets the wanted levels right after a rising edge.
`default_nettype none

module gis_pin_src
    import gis_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] want,
    output logic [7:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************
    // Pin drive
    // ****************************************************
    // Levels are held until the bench moves them; the source has no
    // view of software, so only the bench decides when a level drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins <= 8'h00; // Quiet pins out of reset
        end else begin
            pins <= want;
        end
    end
endmodule // gis_pin_src

`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the GPIO interrupt status block.
// Assumes gis_pkg and gis_top compiled first; one 200 MHz clock.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gis_pkg::*;

    // ****************************************************
    // Signals
    // ****************************************************
    logic pclk = 1'b0; // Bus clock
    logic presetn = 1'b0; // Active low reset
    logic psel = 1'b0; // APB select
    logic penable = 1'b0; // APB enable
    logic pwrite = 1'b0; // APB direction
    logic [11:0] paddr = 12'h000; // APB address
    logic [31:0] pwdata = 32'h0000_0000; // APB write data
    logic [31:0] prdata; // Read data
    logic pready; // Slave ready
    logic pslverr; // Slave error
    logic [7:0] pin_in; // Pins from the source model
    logic [7:0] pin_want = 8'h00; // Levels asked of the source
    logic int_out; // Combined interrupt
    int mismatches = 0; // Failed comparisons
    int cmp_count = 0; // All comparisons
    logic [31:0] rd_q; // Last read data
    logic err_q; // Last error flag

    always #2.5 pclk = ~pclk;

    gis_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .int_out(int_out));

    gis_pin_src src (.pclk(pclk), .presetn(presetn), .want(pin_want), .pins(pin_in));

    // ****************************************************
    // Tasks
    // ****************************************************
    // One comparison, counted
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; starts one edge on so no signal is driven twice
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the slave; only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read and compare
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rd_q, exp);
    endtask

    // Move the pins, then let the synchroniser and detector settle
    task automatic pins(input logic [7:0] v);
        @(posedge pclk);
        pin_want <= v;
        repeat (6) @(posedge pclk);
    endtask

    // Interrupt line sampled mid-cycle, clear of edge updates
    task automatic irq(input logic exp);
        @(negedge pclk);
        check("int_out", {31'h0, int_out}, {31'h0, exp});
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************************
    // Watchdog
    // ****************************************************
    // Tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        report_and_stop();
    end

    // ****************************************************
    // Tests
    // ****************************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of the whole map, then an unmapped place
        for (int i = 0; i < 7; i++) begin
            rd("reset", 12'h404 + 12'(4 * i), 32'h0000_0000);
        end
        rd("unmapped", 12'h420, 32'h0000_0000);
        check("slverr", {31'h0, err_q}, 32'h0000_0001);
        irq(1'b0);
        $display("test reset done");
        // Edges: pin0 rising, pin1 falling only, pin2 both edges
        apb(1'b1, OFF_POLARITY, 32'h0000_0009);
        apb(1'b1, OFF_DUAL_EDGE, 32'h0000_0004);
        pins(8'h07);
        rd("raw rise", OFF_RAW_STAT, 32'h0000_0005);
        rd("mis masked", OFF_MASK_STAT, 32'h0000_0000);
        irq(1'b0);
        apb(1'b1, OFF_INT_MASK, 32'h0000_0001);
        rd("mis open", OFF_MASK_STAT, 32'h0000_0001);
        irq(1'b1);
        apb(1'b1, OFF_CLEAR, 32'h0000_0000);
        rd("raw zero clr", OFF_RAW_STAT, 32'h0000_0005);
        apb(1'b1, OFF_CLEAR, 32'h0000_0001);
        rd("raw one clr", OFF_RAW_STAT, 32'h0000_0004);
        irq(1'b0);
        apb(1'b1, OFF_CLEAR, 32'h0000_0004);
        pins(8'h01);
        rd("raw fall", OFF_RAW_STAT, 32'h0000_0006);
        apb(1'b1, OFF_CLEAR, 32'h0000_00FF);
        rd("raw all clr", OFF_RAW_STAT, 32'h0000_0000);
        $display("test edge done");
        // Levels: pin3 high active, pin4 low active
        apb(1'b1, OFF_DETECT_TYPE, 32'h0000_0018);
        pins(8'h01);
        rd("raw low lvl", OFF_RAW_STAT, 32'h0000_0010);
        pins(8'h09);
        rd("raw high lvl", OFF_RAW_STAT, 32'h0000_0018);
        apb(1'b1, OFF_CLEAR, 32'h0000_00FF);
        rd("raw lvl clr", OFF_RAW_STAT, 32'h0000_0018);
        apb(1'b1, OFF_INT_MASK, 32'h0000_0008);
        rd("mis lvl", OFF_MASK_STAT, 32'h0000_0008);
        irq(1'b1);
        pins(8'h01);
        rd("raw lvl gone", OFF_RAW_STAT, 32'h0000_0010);
        irq(1'b0);
        apb(1'b1, OFF_RAW_STAT, 32'hFFFF_FFFF);
        rd("raw ro", OFF_RAW_STAT, 32'h0000_0010);
        apb(1'b1, OFF_MASK_STAT, 32'hFFFF_FFFF);
        rd("mis ro", OFF_MASK_STAT, 32'h0000_0000);
        // Settings read back as written
        rd("pol back", OFF_POLARITY, 32'h0000_0009);
        rd("dual back", OFF_DUAL_EDGE, 32'h0000_0004);
        rd("sense back", OFF_DETECT_TYPE, 32'h0000_0018);
        rd("mask back", OFF_INT_MASK, 32'h0000_0008);
        rd("clr reads zero", OFF_CLEAR, 32'h0000_0000);
        $display("test level done");
        // Mid-run reset: every register back to zero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd("reset again", OFF_DETECT_TYPE + 12'(4 * i), 32'h0000_0000);
        end
        irq(1'b0);
        $display("test mid reset done");
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
